/* File: inc/dmc_map.svh */
/*
 * dynamic memory controller constants: switch codes, timing counts,
 * register offsets for the AXI4-Lite slave.
 * assumes a 100 ns clock period; included once per compile unit.
 */
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// ---------------------------------------------------------------
// switch codes
// ---------------------------------------------------------------
`define DMC_SIZE_LOW32 4'ha
`define DMC_SIZE_HIGH32 4'h6
`define DMC_SIZE_FULL64 4'hd
// ---------------------------------------------------------------
// timing, in ns and in 100 ns cycles
// ---------------------------------------------------------------
`define DMC_CLK_NS 100
`define DMC_TIMEX_NS 40
`define DMC_TIMEX_CYC ((`DMC_TIMEX_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_CYCLE_NS 280
`define DMC_CYCLE_CYC ((`DMC_CYCLE_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_REFRESH_PERIOD 150
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define DMC_REG_CTRL 4'h0
`define DMC_REG_STATUS 4'h4
`define DMC_REG_REFADDR 4'h8
`define DMC_CTRL_RESET 2'h0
`endif

/* File: inc/dmc_pkg.sv */
/*
 * types for the dynamic memory controller.
 * assumes dmc_map.svh for the numbers.
 */
package dmc_pkg;
  typedef enum logic [3:0] {
    DMC_IDLE = 4'b0001,
    DMC_ROW = 4'b0010,
    DMC_COL = 4'b0100,
    DMC_DONE = 4'b1000
  } dmc_state_e;
  typedef struct packed {
    logic [3:0] ras;
    logic [3:0] cas;
    logic [3:0] we;
    logic [6:0] addr;
  } dmc_array_s;
endpackage : dmc_pkg

/* File: rtl/dmc_top.sv */
/*
 * dynamic memory controller: cpu bus latch, bank select, row/column
 * multiplex, strobe sequencing, refresh and power-loss init to ones.
 * assumes cpu bus pins are asynchronous, the array answers read data
 * by the column phase, and software on AXI4-Lite.
 */
// Contract
// R1: odd parity per byte on writes
// R2: latch address bits 14, 15 for module
// R3: one of four bank selects per cycle; refresh cycles drive all four
// R4: size switch enables address ranges
// R5: latch address 0-13 onto tri-state bus
// R6: seven-bit row then column address bus
// R7: secondary timing point after start
// R8: no new start before 280 ns
// R9: refresh row from counter low bits
// R10: init column from counter high bits
// R11: column strobe off during refresh
// R12: write enable off only in reads
// R13: count pulse clears start, advances counter
// R14: refresh timer requests, refresh flag
// R15: cycles start only from idle
// R16: data-retain latches the address
// R17: drive and observe busy line
// R18: latch read data, assert data available
// R19: separate strobes per 32K half
// R20: power-low raises init reset
// R21: init writes all ones everywhere; code writes bank 0 only
// R22: low power-good means power low
// R23: inhibit ignores power-good, lit indicator
// R24: arbitrate refresh against cpu start
`include "dmc_map.svh"
module dmc_top
  import dmc_pkg::*;
#(
  parameter int REFRESH_PERIOD = `DMC_REFRESH_PERIOD
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [15:0] DATA_IN,
  input wire logic DATA_RETAIN_IN,
  input wire logic READ_IN,
  input wire logic BUSY_IN,
  input wire logic [3:0] SIZE_SW_IN,
  input wire logic POWER_GOOD_IN,
  input wire logic INHIBIT_IN,
  input wire logic [15:0] ARRAY_DATA_IN,
  input wire logic [1:0] ARRAY_PAR_IN,
  output logic [15:0] DATA_OUT,
  output logic [1:0] PAR_OUT,
  output logic DATA_OE_OUT,
  output logic READ_VALID_OUT,
  output logic BUSY_OUT,
  output logic BUSY_OE_OUT,
  output logic [15:0] WDATA_OUT,
  output logic [1:0] WPAR_OUT,
  output dmc_array_s ARRAY_OUT,
  output logic [1:0] COL_SELECT_OUT,
  output logic [13:0] LADDR_OUT,
  output logic LADDR_OE_OUT,
  output logic IDLE_OUT,
  output logic INIT_OUT,
  output logic INHIBIT_LED_OUT,
  input wire logic [3:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [3:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN
);
  localparam logic [1:0] TIMEX_CYC = 2'(`DMC_TIMEX_CYC);
  localparam logic [1:0] CYCLE_CYC = 2'(`DMC_CYCLE_CYC);
  localparam int RW = $clog2(REFRESH_PERIOD + 1);

  function automatic logic odd_par(input logic [7:0] b);
    return ~(^b);
  endfunction : odd_par

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] sync1, sync2;
  always_ff @(posedge REF_CLK_IN) begin
    sync1 <= {DATA_RETAIN_IN, READ_IN, BUSY_IN, POWER_GOOD_IN,
              INHIBIT_IN, SIZE_SW_IN};
    sync2 <= sync1;
  end
  logic retain_s, read_s, busy_s, pok_s, inh_s, retain_d;
  logic [3:0] size_s;
  assign {retain_s, read_s, busy_s, pok_s, inh_s, size_s} = sync2;
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      retain_d <= 1'b0;
    end else begin
      retain_d <= retain_s;
    end
  end
  wire retain_rise = retain_s & ~retain_d;

  // ---------------------------------------------------------------
  // address and data latch
  // ---------------------------------------------------------------
  logic [15:0] cpu_addr, cpu_data;
  logic cpu_read;
  // R16: capture on retain
  // R2: bits 14, 15 latched too
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      cpu_addr <= 16'h0000;
      cpu_data <= 16'h0000;
      cpu_read <= 1'b0;
    end else if (retain_rise) begin
      cpu_addr <= ADDR_IN;
      cpu_data <= DATA_IN;
      cpu_read <= read_s;
    end
  end

  // ---------------------------------------------------------------
  // size switch decode
  // ---------------------------------------------------------------
  logic addr_ok;
  // R4: enabled ranges
  always_comb begin
    unique case (size_s)
      `DMC_SIZE_LOW32: addr_ok = ~ADDR_IN[15];
      `DMC_SIZE_HIGH32: addr_ok = ADDR_IN[15];
      `DMC_SIZE_FULL64: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // power reset and init inhibit
  // ---------------------------------------------------------------
  logic inhibit, init, pok_d;
  // R23: sticky until reset
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      inhibit <= 1'b0;
    end else if (inh_s) begin
      inhibit <= 1'b1;
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      pok_d <= 1'b1;
    end else begin
      pok_d <= pok_s;
    end
  end
  // R22: low power-good
  wire power_reset = ~pok_s & ~inhibit;

  // ---------------------------------------------------------------
  // start flags and arbitration
  // ---------------------------------------------------------------
  dmc_state_e state;
  logic [1:0] tcnt;
  logic count_pulse, refresh, cpu_pend, ref_pend;
  logic [RW-1:0] rtimer;
  logic [13:0] ref_addr;
  wire idle = (state == DMC_IDLE);

  // R17: busy seen before start
  wire cpu_req = retain_rise & addr_ok & ~busy_s;
  // R13: set wins over count clear
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      cpu_pend <= 1'b0;
    end else if (cpu_req) begin
      cpu_pend <= 1'b1;
    end else if (count_pulse & ~refresh & ~init) begin
      cpu_pend <= 1'b0;
    end
  end
  // R14: refresh timer
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      rtimer <= '0;
      ref_pend <= 1'b0;
    end else if (rtimer == RW'(REFRESH_PERIOD - 1)) begin
      rtimer <= '0;
      ref_pend <= 1'b1;
    end else begin
      rtimer <= rtimer + 1'b1;
      if (count_pulse & refresh) begin
        ref_pend <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // R15: start only from idle
  // R24: refresh takes priority
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state <= DMC_IDLE;
      tcnt <= 2'h0;
      refresh <= 1'b0;
    end else begin
      unique case (state)
        DMC_IDLE: begin
          tcnt <= 2'h0;
          if (ref_pend | init) begin
            refresh <= ~init;
            state <= DMC_ROW;
          end else if (cpu_pend) begin
            refresh <= 1'b0;
            state <= DMC_ROW;
          end
        end
        // R7: column after time x
        DMC_ROW: begin
          tcnt <= tcnt + 2'h1;
          if (tcnt + 2'h1 >= TIMEX_CYC) begin
            state <= DMC_COL;
          end
        end
        // R8: row start to count pulse spans 3 cycles, 300 ns
        DMC_COL: begin
          tcnt <= tcnt + 2'h1;
          if (tcnt + 2'h1 >= CYCLE_CYC) begin
            state <= DMC_DONE;
          end
        end
        DMC_DONE: state <= DMC_IDLE;
        default: state <= DMC_IDLE;
      endcase
    end
  end
  assign count_pulse = (state == DMC_DONE);

  // R20: init over all 16K addresses of bank 0
  // R13: counter advances on count
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      ref_addr <= 14'h0000;
      init <= 1'b0;
    end else if (power_reset & pok_d & ~init) begin
      init <= 1'b1;
      ref_addr <= 14'h0000;
    end else if (count_pulse & (refresh | init)) begin
      ref_addr <= ref_addr + 14'h0001;
      if (init & (ref_addr == 14'h3fff)) begin
        init <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // array drive
  // ---------------------------------------------------------------
  logic [13:0] eff_addr;
  logic [1:0] eff_bank;
  logic [3:0] bank_sel;
  always_comb begin
    eff_addr = init ? ref_addr : cpu_addr[13:0];
    eff_bank = init ? 2'h0 : cpu_addr[15:14];
    // R3: one-hot bank select, all four banks during refresh
    bank_sel = 4'h1 << eff_bank;
    if (refresh) begin
      bank_sel = 4'hf;
    end
  end
  wire row_act = ~idle;
  wire col_act = (state == DMC_COL) | (state == DMC_DONE);
  logic [6:0] mux_addr;
  // R6: row then column
  // R9: refresh row only
  // R10: init column high bits
  always_comb begin
    mux_addr = col_act ? eff_addr[13:7] : eff_addr[6:0];
    if (refresh) begin
      mux_addr = ref_addr[6:0];
    end
  end
  // R11: no column strobe in refresh
  // R12: write enable off in reads
  // R19: per-half strobes
  always_comb begin
    ARRAY_OUT.ras = row_act ? bank_sel : 4'h0;
    ARRAY_OUT.cas = (col_act & ~refresh) ? bank_sel : 4'h0;
    ARRAY_OUT.we = (col_act & ~refresh & (init | ~cpu_read)) ?
                   bank_sel : 4'h0;
    ARRAY_OUT.addr = mux_addr;
  end
  assign COL_SELECT_OUT = col_act ? {|bank_sel[3:2], |bank_sel[1:0]}
                                  : 2'h0;
  // R5: cpu latch on the tri-state bus
  assign LADDR_OUT = cpu_addr[13:0];
  assign LADDR_OE_OUT = ~idle & ~refresh & ~init;
  // R21: all ones in init
  // R1: odd byte parity
  assign WDATA_OUT = init ? 16'hffff : cpu_data;
  assign WPAR_OUT = {odd_par(WDATA_OUT[7:0]), odd_par(WDATA_OUT[15:8])};

  // ---------------------------------------------------------------
  // read data and bus answers
  // ---------------------------------------------------------------
  logic rd_valid;
  // R18: latch and present read data
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      DATA_OUT <= 16'h0000;
      PAR_OUT <= 2'h0;
      rd_valid <= 1'b0;
    end else if (count_pulse & ~refresh & ~init & cpu_read) begin
      DATA_OUT <= ARRAY_DATA_IN;
      PAR_OUT <= ARRAY_PAR_IN;
      rd_valid <= 1'b1;
    end else if (retain_rise) begin
      rd_valid <= 1'b0;
    end
  end
  assign READ_VALID_OUT = rd_valid;
  assign DATA_OE_OUT = rd_valid;
  // R17: busy while cycle runs
  assign BUSY_OUT = 1'b1;
  assign BUSY_OE_OUT = cpu_pend | (~idle & ~refresh & ~init);
  assign IDLE_OUT = idle;
  assign INIT_OUT = init;
  assign INHIBIT_LED_OUT = inhibit;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_got, w_got;
  logic [3:0] aw_addr;
  logic [1:0] ctrl;
  // write strobe bit 0 and data bits 1:0, held from the w handshake
  logic [2:0] w_hold;
  assign AWREADY_OUT = ~aw_got & ~BVALID_OUT;
  assign WREADY_OUT = ~w_got & ~BVALID_OUT;
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= 2'h0;
      ctrl <= `DMC_CTRL_RESET;
      w_hold <= 3'h0;
    end else begin
      if (AWVALID_IN & AWREADY_OUT) begin
        aw_got <= 1'b1;
        aw_addr <= AWADDR_IN;
      end
      if (WVALID_IN & WREADY_OUT) begin
        w_got <= 1'b1;
        w_hold <= {WSTRB_IN[0], WDATA_IN[1:0]};
      end
      if (aw_got & w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= (aw_addr == `DMC_REG_CTRL) ? 2'h0 : 2'h2;
        if (aw_addr == `DMC_REG_CTRL && w_hold[2]) begin
          ctrl <= w_hold[1:0];
        end
      end else if (BVALID_OUT & BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end
  assign ARREADY_OUT = ~RVALID_OUT;
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h00000000;
      RRESP_OUT <= 2'h0;
    end else if (ARVALID_IN & ARREADY_OUT) begin
      RVALID_OUT <= 1'b1;
      RRESP_OUT <= 2'h0;
      unique case (ARADDR_IN)
        `DMC_REG_CTRL: RDATA_OUT <= {30'h0, ctrl};
        `DMC_REG_STATUS: RDATA_OUT <= {26'h0, size_s, inhibit,
                                       init};
        `DMC_REG_REFADDR: RDATA_OUT <= {18'h0, ref_addr};
        default: begin
          RDATA_OUT <= 32'h00000000;
          RRESP_OUT <= 2'h2;
        end
      endcase
    end else if (RVALID_OUT & RREADY_IN) begin
      RVALID_OUT <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  cas_refresh_a: assert property (refresh |-> ARRAY_OUT.cas == 4'h0) // R11
    else $error("column strobe in refresh");
  we_read_a: assert property ((~idle & cpu_read & ~init & ~refresh)
    |-> ARRAY_OUT.we == 4'h0) // R12
    else $error("write enable in read");
  bank_onehot_a: assert property ((~idle & ~refresh)
    |-> $onehot(ARRAY_OUT.ras)) // R3
    else $error("bank select not one-hot");
  start_idle_a: assert property ((state == DMC_ROW && $past(state)
    != DMC_ROW) |-> $past(idle)) // R15
    else $error("start not from idle");
  cycle_len_a: assert property ($rose(state == DMC_ROW)
    |-> ##3 count_pulse) // R8
    else $error("cycle length wrong");
  par_a: assert property (WPAR_OUT[1] == ~(^WDATA_OUT[7:0])) // R1
    else $error("left parity wrong");
  init_ones_a: assert property (init |-> WDATA_OUT == 16'hffff) // R21
    else $error("init data not ones");
  read_valid_a: assert property ((count_pulse & cpu_read & ~refresh
    & ~init) |=> READ_VALID_OUT) // R18
    else $error("read valid missing");
  inhibit_a: assert property (inhibit |=> inhibit) // R23
    else $error("inhibit dropped");
  refresh_cov: cover property (count_pulse & refresh);
  read_cov: cover property (count_pulse & cpu_read & ~init);
  init_cov: cover property ($fell(init));
endmodule : dmc_top

/* File: sim/dmc_cpu_model.sv */
/*
 * cpu side of the memory bus: address, write data, retain, read, busy.
 * assumes the caller watches the controller's strobes while it runs.
 */
module dmc_cpu_model (
  input wire logic clk_in,
  output logic [15:0] addr_out,
  output logic [15:0] data_out,
  output logic retain_out,
  output logic read_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // bus access
  // ---------------------------------------------------------------
  initial begin
    addr_out = 16'h0000;
    data_out = 16'h0000;
    retain_out = 1'b0;
    read_out = 1'b0;
    busy_out = 1'b0;
  end
  task automatic access(input logic [15:0] a, d, input logic rd, bsy);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    read_out <= rd;
    busy_out <= bsy;
    @(posedge clk_in);
    retain_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    retain_out <= 1'b0;
    // released bus no longer shows the old value
    addr_out <= ~a;
    data_out <= ~d;
    busy_out <= 1'b0;
  endtask : access
endmodule : dmc_cpu_model

/* File: sim/tb.sv */
/*
 * self-checking bench: cpu cycles, bank select, parity, refresh,
 * init, inhibit, and the AXI4-Lite registers.
 * assumes dmc_top with a short refresh period and a 100 ns clock.
 */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dmc_pkg::*;
  logic REF_CLK_IN, RST_IN, DATA_RETAIN_IN, READ_IN, BUSY_IN;
  logic POWER_GOOD_IN, INHIBIT_IN, AWVALID_IN, WVALID_IN, BREADY_IN;
  logic ARVALID_IN, RREADY_IN, AWREADY_OUT, WREADY_OUT, BVALID_OUT;
  logic ARREADY_OUT, RVALID_OUT, DATA_OE_OUT, READ_VALID_OUT, BUSY_OUT;
  logic BUSY_OE_OUT, LADDR_OE_OUT, IDLE_OUT, INIT_OUT, INHIBIT_LED_OUT;
  logic [15:0] ADDR_IN, DATA_IN, ARRAY_DATA_IN, DATA_OUT, WDATA_OUT;
  logic [3:0] SIZE_SW_IN, AWADDR_IN, WSTRB_IN, ARADDR_IN;
  logic [1:0] ARRAY_PAR_IN, PAR_OUT, WPAR_OUT, COL_SELECT_OUT;
  logic [1:0] BRESP_OUT, RRESP_OUT, rr, c_col, c_par;
  logic [31:0] WDATA_IN, RDATA_OUT, rd;
  logic [13:0] LADDR_OUT;
  logic [3:0] c_ras, c_cas, c_we;
  logic [15:0] a;
  logic hit, c_oe, c_bsy;
  logic [6:0] ra, c_row, c_cadr;
  dmc_array_s ARRAY_OUT;
  int fails = 0, check_count = 0, cyc = 0, n;
  logic [3:0] sz [6] = '{4'ha, 4'ha, 4'h6, 4'h6, 4'h0, 4'h3};
  logic [15:0] sa [6] = '{16'h0010, 16'hc000, 16'hc000, 16'h0010,
                          16'h0010, 16'h0010};
  logic sh [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  dmc_top #(.REFRESH_PERIOD(20)) dut (.*);
  dmc_cpu_model cpu (.clk_in(REF_CLK_IN), .addr_out(ADDR_IN),
    .data_out(DATA_IN), .retain_out(DATA_RETAIN_IN), .read_out(READ_IN),
    .busy_out(BUSY_IN));
  // ---------------------------------------------------------------
  // clock, timeout, closing
  // ---------------------------------------------------------------
  initial begin
    REF_CLK_IN = 1'b0;
    forever #50 REF_CLK_IN = ~REF_CLK_IN;
  end
  always @(posedge REF_CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  function automatic logic [1:0] par(input logic [15:0] d);
    return {~^d[7:0], ~^d[15:8]};
  endfunction : par
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge REF_CLK_IN);
    AWADDR_IN <= ad;
    WDATA_IN <= d;
    WSTRB_IN <= 4'hf;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    do begin
      @(posedge REF_CLK_IN);
      if (AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WREADY_OUT) WVALID_IN <= 1'b0;
    end while (!BVALID_OUT);
    rr = BRESP_OUT;
    BREADY_IN <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] ad);
    @(posedge REF_CLK_IN);
    ARADDR_IN <= ad;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do begin
      @(posedge REF_CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
    end while (!RVALID_OUT);
    rd = RDATA_OUT;
    rr = RRESP_OUT;
    RREADY_IN <= 1'b0;
  endtask : axi_rd
  task automatic op(input logic [15:0] ad, d, input logic r, bsy);
    hit = 1'b0;
    fork
      cpu.access(ad, d, r, bsy);
      repeat (30) begin
        @(posedge REF_CLK_IN);
        // row phase of a single-bank cycle, refresh excluded
        if (!hit && ARRAY_OUT.ras != 4'h0 && ARRAY_OUT.ras != 4'hf &&
            ARRAY_OUT.cas == 4'h0) c_row = ARRAY_OUT.addr;
        if (!hit && ARRAY_OUT.cas != 4'h0) begin
          hit = 1'b1;
          c_cadr = ARRAY_OUT.addr;
          c_oe = LADDR_OE_OUT;
          c_bsy = BUSY_OE_OUT & BUSY_OUT;
          c_ras = ARRAY_OUT.ras;
          c_cas = ARRAY_OUT.cas;
          c_we = ARRAY_OUT.we;
          c_col = COL_SELECT_OUT;
          c_par = WPAR_OUT;
        end
      end
    join
  endtask : op
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    RST_IN = 1'b1;
    {AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN} = 5'h00;
    {AWADDR_IN, ARADDR_IN, WDATA_IN, WSTRB_IN} = 44'h0;
    {INHIBIT_IN, POWER_GOOD_IN} = 2'h1;
    SIZE_SW_IN = 4'hd;
    ARRAY_DATA_IN = 16'h5a3c;
    ARRAY_PAR_IN = 2'h2;
    repeat (12) @(posedge REF_CLK_IN);
    RST_IN <= 1'b0;
    repeat (3) @(posedge REF_CLK_IN);
    axi_rd(4'h0);
    `CHK(rd, 32'h0)
    axi_rd(4'h4);
    `CHK(rd, 32'h34)
    axi_wr(4'h0, 32'h3);
    `CHK(rr, 2'h0)
    axi_wr(4'h4, 32'hff);
    `CHK(rr, 2'h2)
    axi_rd(4'h0);
    `CHK(rd, 32'h3)
    axi_rd(4'h4);
    `CHK(rd, 32'h34)
    axi_rd(4'hc);
    `CHK(rr, 2'h2)
    $display("test registers done");
    for (int b = 0; b < 4; b++) begin
      a = 16'(b * 16'h4000 + 16'h0155 + b);
      op(a, 16'h1234 << b, 1'b0, 1'b0);
      `CHK(hit, 1'b1)
      `CHK(c_cas, 4'h1 << b)
      `CHK(c_ras, 4'h1 << b)
      `CHK(c_we, 4'h1 << b)
      `CHK(c_col, (b < 2) ? 2'h1 : 2'h2)
      `CHK(c_par, par(16'h1234 << b))
      `CHK(LADDR_OUT, a[13:0])
      `CHK(c_oe, 1'b1)
      `CHK(c_row, a[6:0])
      `CHK(c_cadr, a[13:7])
      `CHK(c_bsy, 1'b1)
    end
    $display("test banks done");
    op(16'h8abc, 16'h0000, 1'b1, 1'b0);
    `CHK(c_we, 4'h0)
    `CHK(READ_VALID_OUT, 1'b1)
    `CHK(DATA_OE_OUT, 1'b1)
    `CHK(DATA_OUT, 16'h5a3c)
    `CHK(PAR_OUT, 2'h2)
    op(16'h0040, 16'h0000, 1'b0, 1'b1);
    `CHK(hit, 1'b0)
    $display("test read and busy done");
    for (int i = 0; i < 6; i++) begin
      SIZE_SW_IN <= sz[i];
      op(sa[i], 16'h00ff, 1'b0, 1'b0);
      `CHK(hit, sh[i])
    end
    SIZE_SW_IN <= 4'hd;
    $display("test size switch done");
    n = 0;
    while (ARRAY_OUT.ras !== 4'hf && n < 60) begin
      @(posedge REF_CLK_IN);
      n++;
    end
    `CHK(ARRAY_OUT.ras, 4'hf)
    `CHK(ARRAY_OUT.cas, 4'h0)
    ra = ARRAY_OUT.addr;
    repeat (5) @(posedge REF_CLK_IN);
    axi_rd(4'h8);
    `CHK(rd[6:0], 7'(ra + 7'h1))
    $display("test refresh done");
    POWER_GOOD_IN <= 1'b0;
    n = 0;
    while (ARRAY_OUT.we === 4'h0 && n < 40) begin
      @(posedge REF_CLK_IN);
      n++;
    end
    `CHK(INIT_OUT, 1'b1)
    `CHK(WDATA_OUT, 16'hffff)
    `CHK(WPAR_OUT, 2'h3)
    `CHK(ARRAY_OUT.addr, 7'h0)
    axi_rd(4'h4);
    `CHK(rd, 32'h35)
    RST_IN <= 1'b1;
    POWER_GOOD_IN <= 1'b1;
    repeat (12) @(posedge REF_CLK_IN);
    RST_IN <= 1'b0;
    repeat (3) @(posedge REF_CLK_IN);
    `CHK(IDLE_OUT, 1'b1)
    INHIBIT_IN <= 1'b1;
    repeat (4) @(posedge REF_CLK_IN);
    INHIBIT_IN <= 1'b0;
    repeat (2) @(posedge REF_CLK_IN);
    `CHK(INHIBIT_LED_OUT, 1'b1)
    POWER_GOOD_IN <= 1'b0;
    repeat (20) @(posedge REF_CLK_IN);
    `CHK(INIT_OUT, 1'b0)
    axi_rd(4'h4);
    `CHK(rd, 32'h36)
    $display("test init and inhibit done");
    stop_test();
  end
endmodule : tb
